// ---- hdl/irq_vec_pkg.sv ----
// Constants, register map and carrier types of the event interrupt controller.
// Assumes a single 40 MHz system clock shared with the core and peripherals.
package irq_vec_pkg;
   localparam int NUM_EVT  = 9;
   localparam int NUM_SOFT = 7;
   localparam int NUM_CAND = 16;
   localparam int NUM_HW   = 5;
   localparam int NUM_FLAG = 10;

   // Register indexes of the plain register port
   localparam logic [3:0] REG_EN_LOW    = 4'h0;
   localparam logic [3:0] REG_EN_HIGH   = 4'h1;
   localparam logic [3:0] REG_SERIAL0_RX_PRIORITY_FIELD_BASE = 4'h2;
   localparam logic [3:0] REG_SERIAL0_RX_PRIORITY_FIELD_LAST = 4'h7;
   localparam logic [3:0] REG_FLAGS     = 4'h8;
   localparam logic [3:0] REG_SOFT_REQ  = 4'h9;
   localparam logic [3:0] REG_SOFT_EN   = 4'ha;
   localparam logic [3:0] REG_EXT_MODE  = 4'hb;
   localparam logic [3:0] REG_STATUS    = 4'hc;

   // Field positions
   localparam int GLOBAL_EN_POS = 7;
   localparam int SERIAL0_RX_PRIORITY_FIELD_LO_POS   = 0;
   localparam int SERIAL0_RX_PRIORITY_FIELD_HI_POS   = 4;
   localparam int FLG_EXT0 = 0;
   localparam int FLG_T0   = 1;
   localparam int FLG_EXT1 = 2;
   localparam int FLG_T1   = 3;
   localparam int FLG_T2OV = 4;
   localparam int FLG_T2EX = 5;
   localparam int FLG_S0RX = 6;

   // Reset values
   localparam logic [7:0]  REG8_RST   = 8'h00;
   localparam logic [15:0] REG16_RST  = 16'h0000;

   // Priorities and vectors
   localparam logic [3:0]  EFF_SERIAL0_RX_PRIORITY_FIELD_OFFSET = 4'h8;
   localparam logic [3:0]  EXC_LEVEL       = 4'hf;
   localparam logic [15:0] RESET_VEC       = 16'h0000;
   localparam logic [15:0] HW_TRAP_BASE    = 16'h0004;
   localparam logic [15:0] SW_TRAP_BASE    = 16'h0040;
   localparam logic [15:0] SOFT_BASE       = 16'h0100;
   localparam logic [15:0] EVT_VEC [NUM_EVT] = '{16'h0080, 16'h0084, 16'h0088, 16'h008c,
      16'h0090, 16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac};
   localparam logic [2:0] EVT_SERIAL0_RX_PRIORITY_FIELD_REG [NUM_EVT] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2,
      3'h4, 3'h4, 3'h5, 3'h5};
   localparam logic EVT_SERIAL0_RX_PRIORITY_FIELD_HI [NUM_EVT] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
      1'b0, 1'b1, 1'b0, 1'b1};

   // Source codes reported with a request
   localparam logic [4:0] SRC_RESET  = 5'h10;
   localparam logic [4:0] SRC_HWTRAP = 5'h11;
   localparam logic [4:0] SRC_SWTRAP = 5'h16;
   localparam logic [4:0] SRC_NONE   = 5'h1f;

   typedef struct packed {
      logic t0;
      logic t1;
      logic t2_ovf;
      logic t2_ext;
      logic s0_rx;
      logic s0_tx;
      logic s1_rx;
      logic s1_tx;
   } periph_evt_t;

   typedef struct packed {
      logic        req;
      logic [3:0]  level;
      logic [15:0] vector;
   } irq_out_t;

   typedef enum logic [1:0] {
      ARB_IDLE    = 2'b00,
      ARB_PRESENT = 2'b01,
      ARB_HOLD    = 2'b10
   } arb_state_t;
endpackage

// ---- hdl/event_interrupt_vectoring.sv ----
// Interrupt controller: event flags, enables, priorities, arbitration, vectors.
// Assumes peripherals and core share sys_clk_i; external pins are asynchronous.
//
// Functional notes
// - Nine maskable event sources; global enable cleared blocks all of them.
// - Each event has its own enable in low or high enable register.
// - Each event gets one of eight software-chosen priority levels.
// - Priority is a three-bit field at bits 2..0 or 6..4 of registers 0, 1, 2, 4 and 5 of six.
// - Field zero gives level 0; nonzero n gives level 8 plus n.
// - Equal-level simultaneous requests are served lowest rank first.
// - Ranks 2..10: ext0, t0, ext1, t1, t2, s0 rx, s0 tx, s1 rx, s1 tx.
// - External 0 vectors at 0080, external 1 at 0088.
// - Timer 0 at 0084, timer 1 at 008c, timer 2 two flags share 0090.
// - Serial 0 receive at 00a0, transmit at 00a4, separate flags.
// - Serial 1 uses sixth priority register; transmit 00ac, receive 00a8.
// - Reset is the top exception, vector 0000.
// - Five hardware traps vector from 0004 to 0014, rank 1.
// - Sixteen trap instructions vector through 0040 to 007c, rank 1.
// - All vectors are sixteen-bit values.
// - Reset release raises the reset exception with vector 0000.
// - Enabled level-mode external request wakes from power-down.
// - Logic keeps running in idle; any enabled request wakes.
// - 38 vectored sources: events, soft, traps, exceptions with reset.
// - Seven soft interrupts: own flag, enable, fixed level 1..7, 0100..0118.
`timescale 1ns/1ps
`default_nettype none
module event_interrupt_vectoring #(
   parameter int ADDR_W = 4,
   parameter int DATA_W = 16
) (
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [ADDR_W-1:0]          reg_addr_i,
   input  wire logic [DATA_W-1:0]          reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic [DATA_W-1:0]               reg_rdata_o,
   input  wire logic                       ext0_n_i,
   input  wire logic                       ext1_n_i,
   input  wire irq_vec_pkg::periph_evt_t   periph_evt_i,
   input  wire logic [4:0]                 hw_trap_i,
   input  wire logic                       sw_trap_i,
   input  wire logic [3:0]                 sw_trap_num_i,
   input  wire logic [3:0]                 cpu_serial0_rx_priority_field_i,
   input  wire logic                       ack_i,
   input  wire logic                       idle_i,
   input  wire logic                       power_down_i,
   output irq_vec_pkg::irq_out_t           irq_out_o,
   output logic                            wake_o
);
   logic [7:0]                    irq_enable_low_reg;
   logic [7:0]                    irq_enable_high_reg;
   logic [7:0]                    serial0_rx_priority_field_r [6];
   logic [irq_vec_pkg::NUM_FLAG-1:0] flags_r;
   logic [6:0]                    soft_req_r;
   logic [6:0]                    soft_en_r;
   logic [1:0]                    ext_level_r;
   logic [1:0]                    ext_meta_r;
   logic [1:0]                    ext_sync_r;
   logic [1:0]                    ext_prev_r;
   logic                          reset_pend_r;
   logic [4:0]                    hw_pend_r;
   logic                          sw_pend_r;
   logic [3:0]                    sw_num_r;
   logic [4:0]                    src_r;
   irq_vec_pkg::arb_state_t       state_r;
   logic [8:0]                    en_ev_q;

   // Effective level: nonzero fields behave as if a fourth high bit were set
   function automatic logic [3:0] eff_serial0_rx_priority_field(input logic [2:0] fld);
      return (fld == 3'h0) ? 4'h0 : (irq_vec_pkg::EFF_SERIAL0_RX_PRIORITY_FIELD_OFFSET | {1'b0, fld});
   endfunction

   // Priority field of event source i
   function automatic logic [2:0] serial0_rx_priority_field_field(input int i);
      logic [7:0] r;
      r = serial0_rx_priority_field_r[irq_vec_pkg::EVT_SERIAL0_RX_PRIORITY_FIELD_REG[i]];
      return irq_vec_pkg::EVT_SERIAL0_RX_PRIORITY_FIELD_HI[i] ? r[irq_vec_pkg::SERIAL0_RX_PRIORITY_FIELD_HI_POS +: 3]
                                         : r[irq_vec_pkg::SERIAL0_RX_PRIORITY_FIELD_LO_POS +: 3];
   endfunction

   // Pins are asynchronous: two flops before use
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_meta_r <= 2'h3;
         ext_sync_r <= 2'h3;
         ext_prev_r <= 2'h3;
      end else begin
         ext_meta_r <= {ext1_n_i, ext0_n_i};
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   logic       wr_w;
   logic       glob_w;
   logic [8:0] en_ev_w;
   logic [1:0] ext_fall_w;
   logic [1:0] ext_lvl_req_w;
   logic [1:0] ext_ack_clr_w;
   assign wr_w          = reg_wr_i;
   assign glob_w        = irq_enable_low_reg[irq_vec_pkg::GLOBAL_EN_POS];
   assign en_ev_w       = {irq_enable_high_reg[3:0], irq_enable_low_reg[4:0]};
   assign ext_fall_w    = ext_prev_r & ~ext_sync_r;
   assign ext_lvl_req_w = ~ext_sync_r;
   assign ext_ack_clr_w = {state_r == irq_vec_pkg::ARB_PRESENT && ack_i && src_r == 5'h02,
                           state_r == irq_vec_pkg::ARB_PRESENT && ack_i && src_r == 5'h00};

   // Software-written control registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_enable_low_reg  <= irq_vec_pkg::REG8_RST;
         irq_enable_high_reg <= irq_vec_pkg::REG8_RST;
         soft_req_r          <= 7'h00;
         soft_en_r           <= 7'h00;
         ext_level_r         <= 2'h0;
         for (int k = 0; k < 6; k++) begin
            serial0_rx_priority_field_r[k] <= irq_vec_pkg::REG8_RST;
         end
      end else if (wr_w) begin
         case (reg_addr_i)
            irq_vec_pkg::REG_EN_LOW:   irq_enable_low_reg  <= reg_wdata_i[7:0];
            irq_vec_pkg::REG_EN_HIGH:  irq_enable_high_reg <= {4'h0, reg_wdata_i[3:0]};
            irq_vec_pkg::REG_SOFT_REQ: soft_req_r  <= reg_wdata_i[6:0];
            irq_vec_pkg::REG_SOFT_EN:  soft_en_r   <= reg_wdata_i[6:0];
            irq_vec_pkg::REG_EXT_MODE: ext_level_r <= reg_wdata_i[1:0];
            default: begin
               // fourth bit of each field unused
               if (reg_addr_i >= irq_vec_pkg::REG_SERIAL0_RX_PRIORITY_FIELD_BASE
                   && reg_addr_i <= irq_vec_pkg::REG_SERIAL0_RX_PRIORITY_FIELD_LAST) begin
                  serial0_rx_priority_field_r[3'(reg_addr_i - irq_vec_pkg::REG_SERIAL0_RX_PRIORITY_FIELD_BASE)] <=
                     reg_wdata_i[7:0] & 8'h77;
               end
            end
         endcase
      end
   end

   // Sticky event flags: write one to clear, a same-cycle set wins.
   // Level-mode external flags simply follow the pin.
   logic [irq_vec_pkg::NUM_FLAG-1:0] set_w;
   logic [irq_vec_pkg::NUM_FLAG-1:0] clr_w;
   assign set_w = {periph_evt_i.s1_tx, periph_evt_i.s1_rx, periph_evt_i.s0_tx,
                   periph_evt_i.s0_rx, periph_evt_i.t2_ext, periph_evt_i.t2_ovf,
                   periph_evt_i.t1, ext_fall_w[1], periph_evt_i.t0, ext_fall_w[0]};
   assign clr_w = ((wr_w && reg_addr_i == irq_vec_pkg::REG_FLAGS)
                   ? reg_wdata_i[irq_vec_pkg::NUM_FLAG-1:0] : 10'h000)
                  | {7'h00, ext_ack_clr_w[1], 1'b0, ext_ack_clr_w[0]};

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_r <= 10'h000;
      end else begin
         flags_r <= (flags_r & ~clr_w) | set_w;
         if (ext_level_r[0]) flags_r[irq_vec_pkg::FLG_EXT0] <= ext_lvl_req_w[0];
         if (ext_level_r[1]) flags_r[irq_vec_pkg::FLG_EXT1] <= ext_lvl_req_w[1];
      end
   end

   // Event requests in rank order; timer 2 merges its two flags
   logic [8:0] ev_req_w;
   assign ev_req_w = {flags_r[9:6], flags_r[irq_vec_pkg::FLG_T2OV] | flags_r[irq_vec_pkg::FLG_T2EX],
                      flags_r[3:0]};

   // Candidate selection. Strictly-greater compare keeps the lowest index
   // for a tie, so the loop order is the fixed ranking.
   logic       found_w;
   logic [3:0] best_p_w;
   logic [3:0] best_i_w;
   logic [3:0] cand_p;
   logic       cand_v;
   always_comb begin
      found_w  = 1'b0;
      best_p_w = 4'h0;
      best_i_w = 4'h0;
      cand_p   = 4'h0;
      cand_v   = 1'b0;
      for (int i = 0; i < irq_vec_pkg::NUM_CAND; i++) begin
         if (i < irq_vec_pkg::NUM_EVT) begin
            cand_v = glob_w && en_ev_w[i] && ev_req_w[i];
            cand_p = eff_serial0_rx_priority_field(serial0_rx_priority_field_field(i));
         end else begin
            cand_v = soft_req_r[i-9] && soft_en_r[i-9];
            cand_p = 4'(i - 8);
         end
         if (cand_v && (!found_w || cand_p > best_p_w)) begin
            found_w  = 1'b1;
            best_p_w = cand_p;
            best_i_w = 4'(i);
         end
      end
   end

   // Lowest pending hardware trap
   logic [2:0] hw_idx_w;
   always_comb begin
      hw_idx_w = 3'h0;
      for (int k = irq_vec_pkg::NUM_HW - 1; k >= 0; k--) begin
         if (hw_pend_r[k]) hw_idx_w = 3'(k);
      end
   end

   // all kinds vectored; exceptions and traps outrank events
   logic            any_w;
   logic [4:0]      nsrc_w;
   irq_vec_pkg::irq_out_t nout_w;
   always_comb begin
      any_w  = 1'b1;
      nsrc_w = irq_vec_pkg::SRC_NONE;
      nout_w = '0;
      if (reset_pend_r) begin
         nsrc_w = irq_vec_pkg::SRC_RESET;
         nout_w = '{1'b1, irq_vec_pkg::EXC_LEVEL, irq_vec_pkg::RESET_VEC};
      end else if (hw_pend_r != 5'h00) begin
         nsrc_w = irq_vec_pkg::SRC_HWTRAP + {2'h0, hw_idx_w};
         nout_w = '{1'b1, irq_vec_pkg::EXC_LEVEL,
                    irq_vec_pkg::HW_TRAP_BASE + {11'h000, hw_idx_w, 2'h0}};
      end else if (sw_pend_r) begin
         nsrc_w = irq_vec_pkg::SRC_SWTRAP;
         nout_w = '{1'b1, irq_vec_pkg::EXC_LEVEL,
                    irq_vec_pkg::SW_TRAP_BASE + {10'h000, sw_num_r, 2'h0}};
      end else if (found_w && best_p_w > cpu_serial0_rx_priority_field_i) begin
         nsrc_w = {1'b0, best_i_w};
         nout_w = '{1'b1, best_p_w, (best_i_w < 4'h9) ? irq_vec_pkg::EVT_VEC[best_i_w]
                    : irq_vec_pkg::SOFT_BASE + {10'h000, best_i_w - 4'h9, 2'h0}};
      end else begin
         any_w = 1'b0;
      end
   end

   // Presentation state machine; two quiet cycles after an acknowledge
   // lets the core raise its priority before the next choice.
   logic acked_w;
   assign acked_w = state_r == irq_vec_pkg::ARB_PRESENT && ack_i;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r   <= irq_vec_pkg::ARB_IDLE;
         irq_out_o <= '0;
         src_r     <= irq_vec_pkg::SRC_NONE;
      end else begin
         case (state_r)
            irq_vec_pkg::ARB_IDLE, irq_vec_pkg::ARB_PRESENT: begin
               if (acked_w) begin
                  state_r       <= irq_vec_pkg::ARB_HOLD;
                  irq_out_o.req <= 1'b0;
               end else begin
                  state_r   <= any_w ? irq_vec_pkg::ARB_PRESENT : irq_vec_pkg::ARB_IDLE;
                  irq_out_o <= nout_w;
                  src_r     <= nsrc_w;
               end
            end
            irq_vec_pkg::ARB_HOLD: state_r <= irq_vec_pkg::ARB_IDLE;
            default: state_r <= irq_vec_pkg::ARB_IDLE;
         endcase
      end
   end

   // Exception and trap latches, cleared by acknowledge; new trap wins
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reset_pend_r <= 1'b1;
         hw_pend_r    <= 5'h00;
         sw_pend_r    <= 1'b0;
         sw_num_r     <= 4'h0;
      end else begin
         if (acked_w && src_r == irq_vec_pkg::SRC_RESET) reset_pend_r <= 1'b0;
         hw_pend_r <= (hw_pend_r & ~((acked_w && src_r >= irq_vec_pkg::SRC_HWTRAP
                       && src_r < irq_vec_pkg::SRC_SWTRAP)
                       ? 5'h01 << (src_r - irq_vec_pkg::SRC_HWTRAP) : 5'h00)) | hw_trap_i;
         if (sw_trap_i) begin
            sw_pend_r <= 1'b1;
            sw_num_r  <= sw_trap_num_i;
         end else if (acked_w && src_r == irq_vec_pkg::SRC_SWTRAP) begin
            sw_pend_r <= 1'b0;
         end
      end
   end

   // Wake: idle keeps all logic running; power-down only takes
   // enabled level-mode external requests.
   logic any_en_w;
   logic pd_wake_w;
   assign any_en_w  = (glob_w && |(en_ev_w & ev_req_w)) || |(soft_req_r & soft_en_r);
   assign pd_wake_w = glob_w && |(ext_level_r & ext_lvl_req_w
                      & {irq_enable_low_reg[2], irq_enable_low_reg[0]});
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_o <= 1'b0;
      end else begin
         wake_o <= (idle_i && any_en_w) || (power_down_i && pd_wake_w);
      end
   end

   // Read port: data only in the cycle after the strobe, zero elsewhere
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= irq_vec_pkg::REG16_RST;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            irq_vec_pkg::REG_EN_LOW:   reg_rdata_o <= {8'h00, irq_enable_low_reg};
            irq_vec_pkg::REG_EN_HIGH:  reg_rdata_o <= {8'h00, irq_enable_high_reg};
            irq_vec_pkg::REG_FLAGS:    reg_rdata_o <= {6'h00, flags_r};
            irq_vec_pkg::REG_SOFT_REQ: reg_rdata_o <= {9'h000, soft_req_r};
            irq_vec_pkg::REG_SOFT_EN:  reg_rdata_o <= {9'h000, soft_en_r};
            irq_vec_pkg::REG_EXT_MODE: reg_rdata_o <= {14'h0000, ext_level_r};
            irq_vec_pkg::REG_STATUS:   reg_rdata_o <= {irq_out_o.req, 2'h0, src_r,
                                                       4'h0, irq_out_o.level};
            default: begin
               if (reg_addr_i >= irq_vec_pkg::REG_SERIAL0_RX_PRIORITY_FIELD_BASE
                   && reg_addr_i <= irq_vec_pkg::REG_SERIAL0_RX_PRIORITY_FIELD_LAST) begin
                  reg_rdata_o <= {8'h00, serial0_rx_priority_field_r[3'(reg_addr_i - irq_vec_pkg::REG_SERIAL0_RX_PRIORITY_FIELD_BASE)]};
               end else begin
                  reg_rdata_o <= irq_vec_pkg::REG16_RST;
               end
            end
         endcase
      end else begin
         reg_rdata_o <= irq_vec_pkg::REG16_RST;
      end
   end
   // Helper for checks: enables seen by the last selection
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) en_ev_q <= 9'h000;
      else          en_ev_q <= {9{glob_w}} & en_ev_w;
   end
   sequence s_ack;
      irq_out_o.req && ack_i;
   endsequence
   sequence s_idle_req;
      idle_i && any_en_w;
   endsequence
   property p_global_block;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (irq_out_o.req && !$past(glob_w)) |-> src_r >= 5'h09;
   endproperty
   a_global_block: assert property (p_global_block) else $error("event passed while disabled");
   property p_enable;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (irq_out_o.req && src_r < 5'h09) |-> en_ev_q[src_r[3:0]];
   endproperty
   a_enable: assert property (p_enable) else $error("disabled event presented");
   property p_serial0_rx_priority_field_map;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (irq_out_o.req && src_r < 5'h09) |-> (irq_out_o.level == 4'h0 || irq_out_o.level[3]);
   endproperty
   a_serial0_rx_priority_field_map: assert property (p_serial0_rx_priority_field_map) else $error("bad effective level");
   property p_above_cpu;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (irq_out_o.req && src_r < 5'h10) |-> irq_out_o.level > $past(cpu_serial0_rx_priority_field_i);
   endproperty
   a_above_cpu: assert property (p_above_cpu) else $error("level not above core");
   property p_reset_vec;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (reset_pend_r && !ack_i && state_r != irq_vec_pkg::ARB_HOLD)
         |=> (irq_out_o.req && irq_out_o.vector == 16'h0000);
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset vector missing");
   property p_ack_drop;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_ack |=> !irq_out_o.req ##1 !irq_out_o.req;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
   property p_set_wins;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      periph_evt_i.t0 |=> flags_r[irq_vec_pkg::FLG_T0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("timer 0 event lost");
   property p_idle_wake;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_idle_req |=> wake_o;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle wake missing");
   property p_exc_level;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (irq_out_o.req && src_r >= 5'h10) |-> (irq_out_o.level == 4'hf && irq_out_o.vector < 16'h0080);
   endproperty
   a_exc_level: assert property (p_exc_level) else $error("exception slot wrong");
endmodule
`default_nettype wire

// ---- testbench/core_partner.sv ----
// Core model: acknowledges presented requests and logs the last one taken.
// Assumes irq_out_o is registered by the same clock.
`timescale 1ns/1ps
`default_nettype none
module core_partner (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  ack_en_i,
   input  wire irq_vec_pkg::irq_out_t irq_i,
   output logic                       ack_o,
   output logic [15:0]                vec_o,
   output logic [3:0]                 lvl_o,
   output logic [7:0]                 cnt_o
);
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         cnt_o <= 8'h00;
      end else begin
         ack_o <= ack_en_i && irq_i.req && !ack_o;
         // Ack is a one-cycle pulse; log at the edge that sees ack and req high
         if (ack_o && irq_i.req) begin
            vec_o <= irq_i.vector;
            lvl_o <= irq_i.level;
            cnt_o <= cnt_o + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the event interrupt controller.
// Assumes core_partner stands in for the processor core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic                     clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic                     wr_s = 1'b0, rd_s = 1'b0, swt = 1'b0, pd = 1'b0, idle = 1'b0;
   logic                     ext0_n = 1'b1, ext1_n = 1'b1, ack_en = 1'b1, ack, wake;
   logic [3:0]               addr = 4'h0, swn = 4'h0, cprio = 4'h0, lvl;
   logic [4:0]               hw = 5'h00;
   logic [7:0]               cnt;
   logic [15:0]              wdata = 16'h0000, rdata, vec, d;
   irq_vec_pkg::periph_evt_t evt = '0;
   irq_vec_pkg::irq_out_t    irq;
   int                       n_mismatch = 0, checks_done = 0;
   localparam logic [15:0]   exp_vec [7] = '{16'h0084, 16'h008c, 16'h0090, 16'h00a0,
      16'h00a4, 16'h00a8, 16'h00ac};
   localparam logic [15:0]   clr_mask [7] = '{16'h0002, 16'h0008, 16'h0030, 16'h0040,
      16'h0080, 16'h0100, 16'h0200};

   event_interrupt_vectoring i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .ext0_n_i(ext0_n), .ext1_n_i(ext1_n), .periph_evt_i(evt), .hw_trap_i(hw),
      .sw_trap_i(swt), .sw_trap_num_i(swn), .cpu_serial0_rx_priority_field_i(cprio), .ack_i(ack),
      .idle_i(idle), .power_down_i(pd), .irq_out_o(irq), .wake_o(wake));
   core_partner i_core (.sys_clk_i(clk), .rst_n_i(rst_n), .ack_en_i(ack_en),
      .irq_i(irq), .ack_o(ack), .vec_o(vec), .lvl_o(lvl), .cnt_o(cnt));

   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Register port cycles, one strobe cycle each
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   // Bounded waits for the partner log and for a request
   task automatic wait_cnt(input logic [7:0] n);
      for (int i = 0; i < 40 && cnt !== n; i++) @(posedge clk);
      #1 `CHK(cnt, n)
   endtask
   task automatic wait_req();
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (irq.req === 1'b1) break;
      end
   endtask

   task automatic t_basic();
      wait_cnt(8'h01);
      `CHK(vec, 16'h0000)
      `CHK(lvl, 4'hf)
      wr(4'h2, 16'hffff);
      rd(4'h2);
      `CHK(d, 16'h0077)
      rd(4'hf);
      `CHK(d, 16'h0000)
      $display("test basic done");
   endtask

   task automatic t_timer();
      @(posedge clk) ack_en <= 1'b0;
      wr(4'h2, 16'h0010);
      wr(4'h0, 16'h0082);
      @(posedge clk);
      evt.t0 <= 1'b1;
      @(posedge clk);
      evt <= '0;
      wait_req();
      `CHK(irq.vector, 16'h0084)
      `CHK(irq.level, 4'h9)
      rd(4'hc);
      `CHK(d, 16'h8109)
      @(posedge clk) cprio <= 4'h9;
      repeat (3) @(posedge clk);
      #1 `CHK(irq.req, 1'b0)
      @(posedge clk) cprio <= 4'h0;
      wr(4'h0, 16'h0002);
      repeat (2) @(posedge clk);
      #1 `CHK(irq.req, 1'b0)
      wr(4'h0, 16'h0082);
      wr(4'h2, 16'h0020);
      wait_req();
      `CHK(irq.level, 4'ha)
      @(posedge clk) ack_en <= 1'b1;
      wait_cnt(8'h02);
      `CHK(vec, 16'h0084)
      @(posedge clk);
      ack_en <= 1'b0;
      wr(4'h8, 16'h0002);
      $display("test timer done");
   endtask

   task automatic t_ties();
      wr(4'h0, 16'h009f);
      wr(4'h1, 16'h000f);
      for (int i = 2; i < 8; i++) wr(i[3:0], 16'h0011);
      @(posedge clk);
      evt <= '1;
      @(posedge clk);
      evt <= '0;
      rd(4'h8);
      `CHK(d, 16'h03fa)
      foreach (exp_vec[i]) begin
         wait_req();
         `CHK(irq.vector, exp_vec[i])
         wr(4'h8, clr_mask[i]);
      end
      wr(4'h1, 16'h0000);
      $display("test ties done");
   endtask

   task automatic t_traps();
      ack_en <= 1'b1;
      wr(4'h0, 16'h0081);
      ext0_n <= 1'b0;
      wait_cnt(8'h03);
      `CHK(vec, 16'h0080)
      @(posedge clk) ext0_n <= 1'b1;
      wr(4'h0, 16'h0084);
      ext1_n <= 1'b0;
      wait_cnt(8'h04);
      `CHK(vec, 16'h0088)
      @(posedge clk) ext1_n <= 1'b1;
      wr(4'h0, 16'h0000);
      for (int k = 0; k < 21; k++) begin
         @(posedge clk);
         if (k < 5) hw <= 5'h01 << k;
         else swt <= 1'b1;
         swn <= 4'(k - 5);
         @(posedge clk);
         hw <= 5'h00;
         swt <= 1'b0;
         wait_cnt(8'(5 + k));
         `CHK(vec, (k < 5) ? 16'(4 + 4 * k) : 16'(16'h0040 + 4 * (k - 5)))
      end
      `CHK(lvl, 4'hf)
      $display("test traps done");
   endtask

   task automatic t_soft();
      @(posedge clk) ack_en <= 1'b0;
      wr(4'ha, 16'h007f);
      for (int k = 0; k < 7; k++) begin
         wr(4'h9, 16'h0001 << k);
         wait_req();
         `CHK(irq.vector, 16'(16'h0100 + 4 * k))
         `CHK(irq.level, 4'(k + 1))
         wr(4'h9, 16'h0000);
      end
      // idle wake only with an enabled request
      idle <= 1'b1;
      repeat (3) @(posedge clk);
      #1 `CHK(wake, 1'b0)
      wr(4'h9, 16'h0004);
      repeat (2) @(posedge clk);
      #1 `CHK(wake, 1'b1)
      wr(4'h9, 16'h0000);
      idle <= 1'b0;
      wr(4'hb, 16'h0001);
      wr(4'h0, 16'h0081);
      pd <= 1'b1;
      repeat (4) @(posedge clk);
      #1 `CHK(wake, 1'b0)
      @(posedge clk) ext0_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1 `CHK(wake, 1'b1)
      $display("test soft done");
   endtask

   // Reset for ten cycles, then the scenarios
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_basic();
      t_timer();
      t_ties();
      t_traps();
      t_soft();
      test_done();
   end
   // Watchdog well above the few hundred cycles needed
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire
